// ---- rtl/rom_map_regs.sv ----
`timescale 1ns/1ps
`include "rom_map_consts.svh"
module rom_map_regs import rom_map_pkg::*; (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rd_valid,
  input  wire logic [47:0] rd_offset,
  input  wire logic        fail_valid,
  input  wire logic [47:0] fail_offset,
  input  wire logic [15:0] requester_node_id,
  input  wire logic        bus_reset,
  input  wire logic        reload_valid,
  input  wire logic [21:0] reload_base,
  output logic             map_valid,
  output logic [31:0]      map_addr,
  output logic             irq
);
  // ================================
  // State
  bus_state_t                st_q, st_d;
  logic [21:0]               rom_map_base_q, rom_map_base_d;
  logic                      bib_valid_q, bib_valid_d;
  logic [`IRQ_BITS-1:0]      status_q, status_d;
  logic [`IRQ_BITS-1:0]      mask_q, mask_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      wait_q, wait_d;
  logic                      irq_q, irq_d;
  logic [31:0]               fail_offset_low;
  logic [31:0]               fail_offset_high;
  logic [31:0]               wmask;
  logic [31:0]               base_word;
  logic [`IRQ_BITS-1:0]      events;
  logic                      wr_go;

  // ================================
  // Submodules
  rom_map_addr u_addr (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .rd_valid  (rd_valid),
    .rd_offset (rd_offset),
    .base      (rom_map_base_q),
    .map_valid (map_valid),
    .map_addr  (map_addr)
  );

  fail_capture u_cap (
    .clock             (clock),
    .clk_en            (clk_en),
    .fail_valid        (fail_valid),
    .fail_offset       (fail_offset),
    .requester_node_id (requester_node_id),
    .fail_offset_low   (fail_offset_low),
    .fail_offset_high  (fail_offset_high)
  );

  // ================================
  // Byte lane mask, one generate loop
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_lane
      assign wmask[g*8 +: 8] = {8{avs_byteenable[g]}};
    end
  endgenerate

  assign base_word = {rom_map_base_q, 10'h000};
  assign events    = {bus_reset, rd_valid, fail_valid};

  // ================================
  // Bus slave and registers
  // Every access takes one wait cycle so read data come from a flop
  always_comb begin
    st_d           = st_q;
    rom_map_base_d = rom_map_base_q;
    bib_valid_d    = bib_valid_q;
    mask_d         = mask_q;
    rdata_d        = rdata_q;
    wait_d         = 1'b1;
    wr_go          = 1'b0;
    status_d       = status_q;
    unique case (st_q)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_d   = BUS_REPLY;
          wait_d = 1'b0;
          wr_go  = avs_write;
          rdata_d = 32'h00000000;
          if (avs_read) begin
            unique case (avs_address)
              `OFS_ROM_BASE:   rdata_d = base_word;
              `OFS_FAIL_LOW:   rdata_d = fail_offset_low;
              `OFS_FAIL_HIGH:  rdata_d = fail_offset_high;
              `OFS_IRQ_STATUS: rdata_d = {29'h00000000, status_q};
              `OFS_IRQ_MASK:   rdata_d = {29'h00000000, mask_q};
              `OFS_CONTROL:    rdata_d = {31'h00000000, bib_valid_q};
              default:         rdata_d = 32'h00000000;
            endcase
          end
        end
      end
      BUS_REPLY: begin
        st_d = BUS_IDLE;
      end
      default: begin
        st_d = BUS_IDLE;
      end
    endcase
    if (wr_go) begin
      unique case (avs_address)
        `OFS_ROM_BASE: begin
          rom_map_base_d = (rom_map_base_q & ~wmask[31:10]) | (avs_writedata[31:10] & wmask[31:10]);
        end
        `OFS_IRQ_STATUS: begin
          if (avs_byteenable[0]) begin
            status_d = status_q & ~avs_writedata[`IRQ_BITS-1:0];
          end
        end
        `OFS_IRQ_MASK: begin
          if (avs_byteenable[0]) begin
            mask_d = avs_writedata[`IRQ_BITS-1:0];
          end
        end
        `OFS_CONTROL: begin
          if (avs_byteenable[0]) begin
            bib_valid_d = avs_writedata[`CTRL_BIB_VALID];
          end
        end
        // Capture registers and unmapped offsets ignore writes
        default: begin
          rom_map_base_d = rom_map_base_q;
        end
      endcase
    end
    // Bus reset reloads base only with a valid bus info block
    if (bus_reset && bib_valid_q && reload_valid) begin
      rom_map_base_d = reload_base;
    end
    // Set wins over software clear
    status_d = status_d | events;
    // New mask used so irq never lags a mask write by a cycle
    irq_d    = |(status_d & mask_d);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      st_q           <= BUS_IDLE;
      rom_map_base_q <= `ROM_BASE_RESET;
      bib_valid_q    <= 1'b0;
      status_q       <= '0;
      mask_q         <= '0;
      rdata_q        <= 32'h00000000;
      wait_q         <= 1'b1;
      irq_q          <= 1'b0;
    end else if (clk_en) begin
      st_q           <= st_d;
      rom_map_base_q <= rom_map_base_d;
      bib_valid_q    <= bib_valid_d;
      status_q       <= status_d;
      mask_q         <= mask_d;
      rdata_q        <= rdata_d;
      wait_q         <= wait_d;
      irq_q          <= irq_d;
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;

  // ================================
  // Checks
  // Take strobes mirror the slave's own idle-state acceptance
  logic                      take_rd;
  logic                      take_wr;

  assign take_rd = clk_en && st_q == BUS_IDLE && avs_read;
  assign take_wr = clk_en && st_q == BUS_IDLE && avs_write;

  base_reset_a: assert property (@(posedge clock)
    sys_rst |=> rom_map_base_q == 22'h000000)
    else $error("base not zero after reset");

  base_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && st_q == BUS_IDLE && avs_write && avs_address == `OFS_ROM_BASE && avs_byteenable == 4'hf
    && !bus_reset |=> rom_map_base_q == $past(avs_writedata[31:10]))
    else $error("base write lost");

  low_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
    st_q == BUS_REPLY && $past(avs_read && avs_address == `OFS_ROM_BASE) |-> avs_readdata[9:0] == 10'h000)
    else $error("reserved base bits not zero");

  bib_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && bus_reset && !bib_valid_q && !(st_q == BUS_IDLE && avs_write) |=> $stable(rom_map_base_q))
    else $error("base changed on bus reset without valid block");

  fail_flag_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && fail_valid |=> status_q[`IRQ_BIT_FAIL])
    else $error("failure event not flagged");

  // ================================
  // Handshake and enable checks
  wait_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
    st_q == BUS_IDLE |-> avs_waitrequest)
    else $error("waitrequest low while idle");

  wait_reply_a: assert property (@(posedge clock) disable iff (sys_rst)
    st_q == BUS_REPLY |-> !avs_waitrequest)
    else $error("waitrequest high in reply");

  take_reply_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd || take_wr |=> st_q == BUS_REPLY)
    else $error("request not taken");

  reply_once_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && st_q == BUS_REPLY |=> st_q == BUS_IDLE)
    else $error("reply longer than one cycle");

  idle_stay_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && st_q == BUS_IDLE && !avs_read && !avs_write |=> st_q == BUS_IDLE && $stable(avs_readdata))
    else $error("slave moved without request");

  freeze_bus_a: assert property (@(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(st_q) && $stable(avs_readdata) && $stable(avs_waitrequest))
    else $error("bus state moved with enable low");

  freeze_regs_a: assert property (@(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(rom_map_base_q) && $stable(status_q) && $stable(mask_q)
    && $stable(bib_valid_q) && $stable(irq))
    else $error("registers moved with enable low");

  freeze_map_a: assert property (@(posedge clock) disable iff (sys_rst)
    !clk_en |=> $stable(map_valid) && $stable(map_addr))
    else $error("map output moved with enable low");

  // ================================
  // Read data checks
  read_base_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_ROM_BASE |=> avs_readdata == {$past(rom_map_base_q), 10'h000})
    else $error("base read wrong");

  read_low_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_FAIL_LOW |=> avs_readdata == $past(fail_offset_low))
    else $error("low capture read wrong");

  read_high_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_FAIL_HIGH |=> avs_readdata == $past(fail_offset_high))
    else $error("high capture read wrong");

  read_status_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_IRQ_STATUS |=> avs_readdata == {29'h00000000, $past(status_q)})
    else $error("status read wrong");

  read_mask_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_IRQ_MASK |=> avs_readdata == {29'h00000000, $past(mask_q)})
    else $error("mask read wrong");

  read_ctrl_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && avs_address == `OFS_CONTROL |=> avs_readdata == {31'h00000000, $past(bib_valid_q)})
    else $error("control read wrong");

  read_unmapped_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_rd && !(avs_address inside {`OFS_ROM_BASE, `OFS_FAIL_LOW, `OFS_FAIL_HIGH, `OFS_IRQ_STATUS,
    `OFS_IRQ_MASK, `OFS_CONTROL}) |=> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");

  // ================================
  // Register, interrupt and redirect checks
  mask_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_wr && avs_address == `OFS_IRQ_MASK && avs_byteenable[0]
    |=> mask_q == $past(avs_writedata[`IRQ_BITS-1:0]))
    else $error("mask write lost");

  ctrl_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_wr && avs_address == `OFS_CONTROL && avs_byteenable[0]
    |=> bib_valid_q == $past(avs_writedata[`CTRL_BIB_VALID]))
    else $error("control write lost");

  ro_write_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_wr && (avs_address == `OFS_FAIL_LOW || avs_address == `OFS_FAIL_HIGH) && !bus_reset
    |=> $stable(rom_map_base_q) && $stable(mask_q) && $stable(bib_valid_q))
    else $error("capture write disturbed registers");

  reload_base_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && bus_reset && bib_valid_q && reload_valid |=> rom_map_base_q == $past(reload_base))
    else $error("base not reloaded on bus reset");

  read_event_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && rd_valid |=> status_q[`IRQ_BIT_ROM_READ])
    else $error("rom read event not flagged");

  reset_event_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && bus_reset |=> status_q[`IRQ_BIT_BUS_RESET])
    else $error("bus reset event not flagged");

  status_clear_a: assert property (@(posedge clock) disable iff (sys_rst)
    take_wr && avs_address == `OFS_IRQ_STATUS && avs_byteenable[0] && avs_writedata[`IRQ_BIT_FAIL]
    && !fail_valid |=> !status_q[`IRQ_BIT_FAIL])
    else $error("status bit not cleared");

  status_sticky_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && status_q[`IRQ_BIT_FAIL] && !(take_wr && avs_address == `OFS_IRQ_STATUS)
    |=> status_q[`IRQ_BIT_FAIL])
    else $error("status bit lost without clear");

  irq_level_a: assert property (@(posedge clock) disable iff (sys_rst)
    irq == |(status_q & mask_q))
    else $error("irq not matching masked status");

  map_miss_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !(rd_valid && rd_offset[47:10] == 38'h3ffffc0001) |=> !map_valid)
    else $error("redirect outside rom window");

  map_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && !rd_valid |=> $stable(map_addr))
    else $error("map address moved without read");
endmodule

// ---- rtl/rom_map_consts.svh ----
// Notes on behaviour
// - ROM-window quadlet read address equals base plus offset[9:0]
// - Base bits 31-10 read/write, reset zero
// - Low ten base bits always read zero
// - Posted write failure captures details into two registers
// - Low capture holds destination offset bits 31-0
// - High capture bits 15-0 hold offset bits 47-32
// - High capture upper half holds bus and node number
// - Bus reset without valid info block keeps base
`ifndef ROM_MAP_CONSTS_SVH
`define ROM_MAP_CONSTS_SVH

`define OFS_ROM_BASE      8'h34
`define OFS_FAIL_LOW      8'h38
`define OFS_FAIL_HIGH     8'h3c
`define OFS_IRQ_STATUS    8'h44
`define OFS_IRQ_MASK      8'h48
`define OFS_CONTROL       8'h4c
`define ROM_BASE_RESET    22'h000000
`define ROM_BASE_LSB      10
`define ROM_WIN_FIRST     48'hfffff0000400
`define ROM_WIN_LAST      48'hfffff00007ff
`define IRQ_BIT_FAIL      0
`define IRQ_BIT_ROM_READ  1
`define IRQ_BIT_BUS_RESET 2
`define IRQ_BITS          3
`define CTRL_BIB_VALID    0

`endif

// ---- rtl/rom_map_pkg.sv ----
package rom_map_pkg;
  typedef enum logic [1:0] {
    BUS_IDLE  = 2'b00,
    BUS_REPLY = 2'b01
  } bus_state_t;
endpackage

// ---- rtl/rom_map_addr.sv ----
`timescale 1ns/1ps
`include "rom_map_consts.svh"
// ================================
// Configuration ROM read redirect
module rom_map_addr (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        rd_valid,
  input  wire logic [47:0] rd_offset,
  input  wire logic [21:0] base,
  output logic             map_valid,
  output logic [31:0]      map_addr
);
  logic        hit;
  logic        valid_d;
  logic [31:0] addr_d;

  always_comb begin
    hit     = rd_valid && (rd_offset >= `ROM_WIN_FIRST) && (rd_offset <= `ROM_WIN_LAST);
    valid_d = hit;
    addr_d  = map_addr;
    if (hit) begin
      addr_d = {base, 10'h000} + {22'h000000, rd_offset[9:0]};
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      map_valid <= 1'b0;
      map_addr  <= 32'h00000000;
    end else if (clk_en) begin
      map_valid <= valid_d;
      map_addr  <= addr_d;
    end
  end

  map_addr_a: assert property (@(posedge clock) disable iff (sys_rst)
    clk_en && rd_valid && rd_offset[47:10] == 38'h3ffffc0001
    |=> map_valid && map_addr == {$past(base), $past(rd_offset[9:0])})
    else $error("rom window address mismatch");
endmodule

// ---- rtl/fail_capture.sv ----
`timescale 1ns/1ps
// ================================
// Posted write failure capture
module fail_capture (
  input  wire logic        clock,
  input  wire logic        clk_en,
  input  wire logic        fail_valid,
  input  wire logic [47:0] fail_offset,
  input  wire logic [15:0] requester_node_id,
  output logic [31:0]      fail_offset_low,
  output logic [31:0]      fail_offset_high
);
  logic [31:0] low_d;
  logic [31:0] high_d;

  // No reset: contents hold until the next failure
  always_comb begin
    low_d  = fail_offset_low;
    high_d = fail_offset_high;
    if (fail_valid) begin
      low_d  = fail_offset[31:0];
      high_d = {requester_node_id, fail_offset[47:32]};
    end
  end

  always_ff @(posedge clock) begin
    if (clk_en) begin
      fail_offset_low  <= low_d;
      fail_offset_high <= high_d;
    end
  end

  capture_low_a: assert property (@(posedge clock)
    clk_en && fail_valid |=> fail_offset_low == $past(fail_offset[31:0]))
    else $error("low capture wrong");
  capture_high_a: assert property (@(posedge clock)
    clk_en && fail_valid |=> fail_offset_high[15:0] == $past(fail_offset[47:32]))
    else $error("high offset capture wrong");
  capture_src_a: assert property (@(posedge clock)
    clk_en && fail_valid |=> fail_offset_high[31:16] == $past(requester_node_id))
    else $error("source id capture wrong");
  capture_hold_a: assert property (@(posedge clock)
    clk_en && !fail_valid |=> $stable(fail_offset_low) && $stable(fail_offset_high))
    else $error("capture changed without failure");
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "rom_map_consts.svh"
module tb_top import rom_map_pkg::*;;
  typedef struct packed {logic [31:0] base; logic [47:0] ofs; logic [31:0] addr;} row_t;
  logic        clock;
  logic        sys_rst;
  logic        clk_en;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rd_valid;
  logic [47:0] rd_offset;
  logic        fail_valid;
  logic [47:0] fail_offset;
  logic [15:0] requester_node_id;
  logic        bus_reset;
  logic        reload_valid;
  logic [21:0] reload_base;
  logic        map_valid;
  logic [31:0] map_addr;
  logic        irq;
  logic [31:0] rd;
  int          failures = 0;
  int          checks = 0;
  // Window edges and one mid value; base low bits must be dropped
  row_t rows[3] = '{'{32'h0000_0400, 48'hfffff0000400, 32'h0000_0400},
                    '{32'hffff_ffff, 48'hfffff00007ff, 32'hffff_ffff},
                    '{32'h1234_5678, 48'hfffff0000555, 32'h1234_5555}};

  rom_map_regs uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_valid(rd_valid),
    .rd_offset(rd_offset), .fail_valid(fail_valid), .fail_offset(fail_offset),
    .requester_node_id(requester_node_id), .bus_reset(bus_reset), .reload_valid(reload_valid),
    .reload_base(reload_base), .map_valid(map_valid), .map_addr(map_addr), .irq(irq));

  // ================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clock);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_write <= wr;
    avs_read <= ~wr;
    // No local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask

  task automatic pulse(input int sel, input logic [47:0] ofs);
    @(posedge clock);
    case (sel)
      0: begin
        rd_offset <= ofs;
        rd_valid <= 1'b1;
      end
      1: begin
        fail_offset <= ofs;
        fail_valid <= 1'b1;
      end
      default: bus_reset <= 1'b1;
    endcase
    @(posedge clock);
    rd_valid <= 1'b0;
    fail_valid <= 1'b0;
    bus_reset <= 1'b0;
  endtask

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Whole run is a little over a hundred cycles
  initial begin
    repeat (5000) @(posedge clock);
    failures++;
    conclude();
  end

  // ================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    rd_valid = 1'b0;
    rd_offset = 48'h0;
    fail_valid = 1'b0;
    fail_offset = 48'h0;
    requester_node_id = 16'h0;
    bus_reset = 1'b0;
    reload_valid = 1'b0;
    reload_base = 22'h0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rd_chk(`OFS_ROM_BASE, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, `OFS_ROM_BASE, rows[i].base);
      rd_chk(`OFS_ROM_BASE, rows[i].base & 32'hffff_fc00);
      pulse(0, rows[i].ofs);
      @(negedge clock);
      check({31'h0, map_valid}, 32'h1);
      check(map_addr, rows[i].addr);
    end
    // Just outside the window on both sides: no redirect
    pulse(0, 48'hfffff00003ff);
    @(negedge clock);
    check({31'h0, map_valid}, 32'h0);
    pulse(0, 48'hfffff0000800);
    @(negedge clock);
    check({31'h0, map_valid}, 32'h0);
    rd_chk(8'h00, 32'h0);
    // Partial byte write: only the top lane of the base may move
    avs_byteenable <= 4'h8;
    bus(1'b1, `OFS_ROM_BASE, 32'hffff_ffff);
    avs_byteenable <= 4'hf;
    rd_chk(`OFS_ROM_BASE, 32'hff34_5400);
    // ================================
    // Failure capture, overwrite, ignored writes, interrupt
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    requester_node_id <= 16'hb5c3;
    pulse(1, 48'h89ab_0123_4567);
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h1);
    rd_chk(`OFS_FAIL_LOW, 32'h0123_4567);
    rd_chk(`OFS_FAIL_HIGH, 32'hb5c3_89ab);
    requester_node_id <= 16'h4a2e;
    pulse(1, 48'h1357_fedc_ba98);
    bus(1'b1, `OFS_FAIL_LOW, 32'hffff_ffff);
    bus(1'b1, `OFS_FAIL_HIGH, 32'h0);
    rd_chk(`OFS_FAIL_LOW, 32'hfedc_ba98);
    rd_chk(`OFS_FAIL_HIGH, 32'h4a2e_1357);
    // Enable low: a failure must leave the capture untouched
    clk_en <= 1'b0;
    pulse(1, 48'h0000_1111_2222);
    clk_en <= 1'b1;
    rd_chk(`OFS_FAIL_LOW, 32'hfedc_ba98);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'h1);
    repeat (2) @(negedge clock);
    check({31'h0, irq}, 32'h0);
    // ================================
    // Bus reset reload gated by info block valid
    bus(1'b1, `OFS_ROM_BASE, 32'h0000_0c00);
    reload_valid <= 1'b1;
    reload_base <= 22'h2aaaaa;
    pulse(2, 48'h0);
    rd_chk(`OFS_ROM_BASE, 32'h0000_0c00);
    bus(1'b1, `OFS_CONTROL, 32'h1);
    pulse(2, 48'h0);
    rd_chk(`OFS_ROM_BASE, 32'haaaa_a800);
    // Raise irq first so the reset has something to clear
    bus(1'b1, `OFS_IRQ_MASK, 32'h7);
    @(negedge clock);
    check({31'h0, irq}, 32'h1);
    // Reset in mid-run clears the base again
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    check({31'h0, irq}, 32'h0);
    check({31'h0, avs_waitrequest}, 32'h1);
    check({31'h0, map_valid}, 32'h0);
    check(map_addr, 32'h0);
    check(avs_readdata, 32'h0);
    rd_chk(`OFS_ROM_BASE, 32'h0);
    conclude();
  end
endmodule
